// File: meter_serial_defines.vh
// Constants for the meter's serial register slave: link timing, frame codes,
// register offsets and status bit positions.
// Assumes the including module runs on one 20 MHz clock.
`ifndef METER_SERIAL_DEFINES_VH
`define METER_SERIAL_DEFINES_VH

// Link timing
`define CLK_HZ 20000000
`define BAUD_RATE 19200
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define CHAR_BITS 10
`define GAP_CHARS 7
`define GAP_CYCLES (`GAP_CHARS * `CHAR_BITS * `BIT_CYCLES)

// Frame codes
`define FUNC_READ_HOLDING 8'h03
`define FUNC_EXC_FLAG 8'h80
`define EXC_ILLEGAL_FUNC 8'h01
`define EXC_ILLEGAL_ADDR 8'h02
`define REQ_LEN 8'h08
`define MIN_FRAME_LEN 8'h04
`define RESP_HDR_LEN 8'h05
`define EXC_RESP_LEN 8'h05
`define DATA_BYTE0 8'h03
`define BROADCAST_ADDR 8'h00
`define MAX_QTY 16'h007D
`define REG_SPAN 17'h0001A
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define CRC_GOOD 16'h0000

// Holding register start offsets, two registers each
`define REG_GAS_TEMP 8'h00
`define REG_LINE_PRESS 8'h02
`define REG_FWD_VEL 8'h04
`define REG_FWD_FLOW 8'h06
`define REG_FWD_TOTAL 8'h08
`define REG_BWD_VEL 8'h0A
`define REG_BWD_FLOW 8'h0C
`define REG_BWD_TOTAL 8'h0E
`define REG_COND_FLAGS 8'h18

// Condition flag bit positions
`define ST_MEAS_OVR 2
`define ST_TEMP_OVR 3
`define ST_PRESS_OVR 4
`define ST_PULSE_OVR 5
`define ST_CAL_DUE 6
`define ST_DP_FAIL 8
`define ST_PRESS_FAIL 9
`define ST_TEMP_FAIL 10
`define ST_THERM_FAIL 11
`define ST_REVERSE 15
`define ST_WIRELESS 16

`endif

// File: meter_serial_props.sv
// Checker for the serial register slave: reply timing, driver enable, address.
// Assumes it is bound to the slave and sees only its ports.
`timescale 1ns/1ns
module meter_serial_props #(
	parameter BIT_CYC = 16,
	parameter GAP_CYC = 1120
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire rs485_rx_in,
	input wire [3:0] serial_tens_in,
	input wire [3:0] serial_ones_in,
	input wire cfg_addr_load_in,
	input wire [7:0] cfg_addr_in,
	input wire rs485_tx_out,
	input wire rs485_drive_n_out,
	input wire [7:0] bus_addr_out,
	input wire poll_busy_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	reg [31:0] idle_r;
	reg [31:0] busy_r;
	// Idle and busy run lengths; the idle count saturates so it cannot wrap
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			idle_r <= 0;
			busy_r <= 0;
		end else begin
			idle_r <= rs485_rx_in ? (idle_r < GAP_CYC ? idle_r + 1 : idle_r) : 0;
			busy_r <= poll_busy_out ? busy_r + 1 : 0;
		end
	end
	a_driver_when_busy: assert property (!poll_busy_out |-> rs485_drive_n_out) else $error("driver on while idle");
	a_line_idle_high: assert property (rs485_drive_n_out |-> rs485_tx_out) else $error("tx low while released");
	a_start_bit: assert property ($fell(rs485_drive_n_out) |-> !rs485_tx_out [*4]) else $error("short start bit");
	a_gap_first: assert property ($fell(rs485_drive_n_out) |-> idle_r >= GAP_CYC) else $error("reply before gap");
	a_busy_start: assert property ($rose(poll_busy_out) |-> $fell(rs485_drive_n_out)) else $error("busy without driver");
	a_reply_bound: assert property (busy_r < 610 * BIT_CYC) else $error("reply too long");
	a_one_poll: assert property ($fell(poll_busy_out) |-> !poll_busy_out [*8]) else $error("reply restarted");
	a_addr_load: assert property (cfg_addr_load_in |=> bus_addr_out == $past(cfg_addr_in)) else $error("load lost");
	a_addr_strap: assert property ($fell(sys_rst_in) && !cfg_addr_load_in |=>
		bus_addr_out == $past(serial_tens_in) * 10 + $past(serial_ones_in)) else $error("strap address wrong");
	a_addr_hold: assert property (!cfg_addr_load_in && !$fell(sys_rst_in) |=> $stable(bus_addr_out))
		else $error("address moved");
endmodule // meter_serial_props

bind meter_serial_register_slave meter_serial_props #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC)) meter_serial_props_inst (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rs485_rx_in(rs485_rx_in), .serial_tens_in(serial_tens_in),
	.serial_ones_in(serial_ones_in), .cfg_addr_load_in(cfg_addr_load_in), .cfg_addr_in(cfg_addr_in),
	.rs485_tx_out(rs485_tx_out), .rs485_drive_n_out(rs485_drive_n_out), .bus_addr_out(bus_addr_out),
	.poll_busy_out(poll_busy_out));

// File: meter_serial_register_slave.v
// Serial fieldbus register slave of the flow meter: answers read requests with values and flags.
// Assumes values and flags come from logic on clk_in; only the receive pin is asynchronous.
// What this block does
// - Bus address from serial number's last two digits; 19200 8N1, seven-character frame gap.
// - Read-holding-registers requests, code 03, are answered with the requested contents.
// - Four-byte values go out as byte 1, byte 0, byte 3, byte 2.
// - Sixteen-bit words go out high byte then low byte.
// - Nine 32-bit values at even start addresses 0 to 14 and 24.
// - Operating condition is a 32-bit word of independent flags.
// - Flag bits 2 to 6 mark over-range conditions and overdue calibration.
// - Flag bits 8 to 11 mark failed sensors and failed thermistor.
// - Bit 15 shows reverse flow, bit 16 a connected wireless service module.
// - Only one poll is served at a time; no concurrent requests.
// - Bus address may be changed at run time from the configuration side.
`timescale 1ns/1ns
`include "meter_serial_defines.vh"

module meter_serial_register_slave #(
	parameter BIT_CYC = `BIT_CYCLES,
	parameter GAP_CYC = `GAP_CYCLES
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire rs485_rx_in,
	input wire [3:0] serial_tens_in,
	input wire [3:0] serial_ones_in,
	input wire cfg_addr_load_in,
	input wire [7:0] cfg_addr_in,
	input wire [31:0] gas_temperature_value_in,
	input wire [31:0] line_pressure_value_in,
	input wire [31:0] forward_velocity_value_in,
	input wire [31:0] forward_flow_value_in,
	input wire [31:0] forward_total_count_in,
	input wire [31:0] backward_velocity_value_in,
	input wire [31:0] backward_flow_value_in,
	input wire [31:0] backward_total_count_in,
	input wire meas_over_range_in,
	input wire temp_over_range_in,
	input wire press_over_range_in,
	input wire pulse_over_range_in,
	input wire calib_overdue_in,
	input wire dp_sensor_fail_in,
	input wire press_sensor_fail_in,
	input wire temp_sensor_fail_in,
	input wire thermistor_element_fail_in,
	input wire reverse_flow_in,
	input wire wireless_service_module_in,
	output wire rs485_tx_out,
	output wire rs485_drive_n_out,
	output wire [7:0] bus_addr_out,
	output wire poll_busy_out
);
	localparam RX_IDLE = 2'b00;
	localparam RX_START = 2'b01;
	localparam RX_DATA = 2'b10;
	localparam RX_STOP = 2'b11;
	reg rx_s1_r, rx_s2_r, rx_s3_r, rx_line_r, rx_bad_r, strap_pend_r;
	reg tx_busy_r, tx_pin_r, drive_n_r;
	reg [1:0] rx_state_r;
	reg [2:0] rx_bit_r;
	reg [3:0] tx_bit_r;
	reg [7:0] rx_sh_r, rx_cnt_r, addr_r;
	reg [7:0] tx_idx_r, tx_len_r, tx_exc_r, tx_func_r, tx_start_r, tx_qty_r;
	reg [8:0] tx_sh_r;
	reg [15:0] rx_bcnt_r, rx_crc_r, tx_crc_r, tx_bcnt_r;
	reg [23:0] gap_r;
	reg [7:0] rx_buf [0:7];
	wire eof, frame_ok, req_range_ok;
	wire [7:0] next_idx;
	wire [15:0] req_start, req_qty;
	wire [16:0] req_end;
	wire [31:0] cond_word;
	// Condition word built from live flags; undefined bits read zero
	assign cond_word = {15'h0000, wireless_service_module_in, reverse_flow_in, 3'h0,
		thermistor_element_fail_in, temp_sensor_fail_in, press_sensor_fail_in, dp_sensor_fail_in, 1'b0,
		calib_overdue_in, pulse_over_range_in, press_over_range_in, temp_over_range_in,
		meas_over_range_in, 2'h0};
	// Byte-serial CRC, reflected polynomial
	function [15:0] crc_upd;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] x;
		begin
			x = c ^ {8'h00, d};
			for (i = 0; i < 8; i = i + 1) begin
				x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
			end
			crc_upd = x;
		end
	endfunction
	// Register map lookup by register number
	function [31:0] value_at;
		input [7:0] r;
		begin
			case ({r[7:1], 1'b0})
				`REG_GAS_TEMP: value_at = gas_temperature_value_in;
				`REG_LINE_PRESS: value_at = line_pressure_value_in;
				`REG_FWD_VEL: value_at = forward_velocity_value_in;
				`REG_FWD_FLOW: value_at = forward_flow_value_in;
				`REG_FWD_TOTAL: value_at = forward_total_count_in;
				`REG_BWD_VEL: value_at = backward_velocity_value_in;
				`REG_BWD_FLOW: value_at = backward_flow_value_in;
				`REG_BWD_TOTAL: value_at = backward_total_count_in;
				`REG_COND_FLAGS: value_at = cond_word;
				default: value_at = 32'h00000000;
			endcase
		end
	endfunction
	// Byte at a response position; CRC bytes are taken from the running sum
	function [7:0] byte_at;
		input [7:0] k;
		reg [7:0] j, r;
		reg [31:0] w;
		reg [15:0] h;
		begin
			j = k - `DATA_BYTE0;
			r = tx_start_r + {1'b0, j[7:1]};
			w = value_at(r);
			h = r[0] ? w[31:16] : w[15:0]; // Even register carries bytes 1,0, odd carries 3,2
			if (k == tx_len_r - 8'h02)
				byte_at = tx_crc_r[7:0];
			else if (k == tx_len_r - 8'h01)
				byte_at = tx_crc_r[15:8];
			else if (k == 8'h00)
				byte_at = addr_r;
			else if (k == 8'h01)
				byte_at = tx_func_r;
			else if (k == 8'h02)
				byte_at = (tx_exc_r != 8'h00) ? tx_exc_r : {tx_qty_r[6:0], 1'b0};
			else
				byte_at = j[0] ? h[7:0] : h[15:8]; // High byte first
		end
	endfunction
	// Receive pin synchroniser; a level counts once stages two and three agree
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_s3_r <= 1'b1;
			rx_line_r <= 1'b1;
		end else begin
			rx_s1_r <= rs485_rx_in;
			rx_s2_r <= rx_s1_r;
			rx_s3_r <= rx_s2_r;
			if (rx_s2_r == rx_s3_r)
				rx_line_r <= rx_s3_r;
		end
	end
	// Frame ends after seven idle characters
	assign eof = (gap_r == GAP_CYC - 1) && (rx_cnt_r != 8'h00);
	// Receiver: 8N1 bytes, frame buffer, running CRC and gap timer
	// Shift register and bit count need no reset: every start bit reloads or refills them
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			rx_state_r <= RX_IDLE;
			rx_bcnt_r <= 16'h0000;
			rx_cnt_r <= 8'h00;
			rx_bad_r <= 1'b0;
			rx_crc_r <= `CRC_INIT;
			gap_r <= 24'h000000;
		end else begin
			if (rx_state_r != RX_IDLE || !rx_line_r)
				gap_r <= 24'h000000;
			else if (gap_r != GAP_CYC - 1)
				gap_r <= gap_r + 24'h000001;
			if (eof) begin
				rx_cnt_r <= 8'h00;
				rx_bad_r <= 1'b0;
				rx_crc_r <= `CRC_INIT;
			end
			case (rx_state_r)
				RX_IDLE: begin
					if (!rx_line_r) begin
						rx_state_r <= RX_START;
						rx_bcnt_r <= 16'h0000;
					end
				end
				RX_START: begin
					if (rx_bcnt_r == BIT_CYC / 2 - 1) begin
						rx_bcnt_r <= 16'h0000;
						rx_bit_r <= 3'h0;
						rx_state_r <= rx_line_r ? RX_IDLE : RX_DATA; // Glitch shorter than half a bit
					end else
						rx_bcnt_r <= rx_bcnt_r + 16'h0001;
				end
				RX_DATA: begin
					if (rx_bcnt_r == BIT_CYC - 1) begin
						rx_bcnt_r <= 16'h0000;
						rx_sh_r <= {rx_line_r, rx_sh_r[7:1]};
						rx_bit_r <= rx_bit_r + 3'h1;
						if (rx_bit_r == 3'h7)
							rx_state_r <= RX_STOP;
					end else
						rx_bcnt_r <= rx_bcnt_r + 16'h0001;
				end
				RX_STOP: begin
					if (rx_bcnt_r == BIT_CYC - 1) begin
						rx_state_r <= RX_IDLE;
						if (!rx_line_r)
							rx_bad_r <= 1'b1; // Framing error spoils the whole frame
						else begin
							if (rx_cnt_r < `REQ_LEN)
								rx_buf[rx_cnt_r[2:0]] <= rx_sh_r;
							if (rx_cnt_r != 8'hFF)
								rx_cnt_r <= rx_cnt_r + 8'h01;
							rx_crc_r <= crc_upd(rx_crc_r, rx_sh_r);
						end
					end else
						rx_bcnt_r <= rx_bcnt_r + 16'h0001;
				end
				default: rx_state_r <= RX_IDLE;
			endcase
		end
	end
	// Address from the strap digits after reset release; config may override
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			addr_r <= 8'h00;
			strap_pend_r <= 1'b1;
		end else if (cfg_addr_load_in) begin
			addr_r <= cfg_addr_in; // Run-time change wins over the strap
			strap_pend_r <= 1'b0;
		end else if (strap_pend_r) begin
			addr_r <= {1'b0, serial_tens_in, 3'h0} + {3'h0, serial_tens_in, 1'b0} + {4'h0, serial_ones_in};
			strap_pend_r <= 1'b0;
		end
	end
	// Request decode: CRC good, our address, and not while a reply is going out
	assign frame_ok = eof && !rx_bad_r && (rx_crc_r == `CRC_GOOD) && (rx_cnt_r >= `MIN_FRAME_LEN) &&
		(rx_buf[0] == addr_r) && (rx_buf[0] != `BROADCAST_ADDR) && !tx_busy_r;
	assign req_start = {rx_buf[2], rx_buf[3]};
	assign req_qty = {rx_buf[4], rx_buf[5]};
	assign req_end = {1'b0, req_start} + {1'b0, req_qty};
	assign req_range_ok = (req_qty != 16'h0000) && (req_qty <= `MAX_QTY) && (req_end <= `REG_SPAN);
	assign next_idx = tx_idx_r + 8'h01;
	// Transmitter: loads one response byte at a time, appends CRC low then high
	// Only the busy flag and the line state are reset; the reply registers are all loaded when a reply starts
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_busy_r <= 1'b0;
			tx_pin_r <= 1'b1;
			drive_n_r <= 1'b1;
		end else if (!tx_busy_r) begin
			if (frame_ok && (rx_buf[1] != `FUNC_READ_HOLDING || rx_cnt_r == `REQ_LEN)) begin
				tx_busy_r <= 1'b1;
				drive_n_r <= 1'b0;
				tx_pin_r <= 1'b0;
				tx_sh_r <= {1'b1, addr_r};
				tx_crc_r <= crc_upd(`CRC_INIT, addr_r);
				tx_idx_r <= 8'h00;
				tx_bit_r <= 4'h0;
				tx_bcnt_r <= 16'h0000;
				tx_start_r <= req_start[7:0];
				tx_qty_r <= req_qty[7:0];
				if (rx_buf[1] != `FUNC_READ_HOLDING) begin
					tx_func_r <= rx_buf[1] | `FUNC_EXC_FLAG;
					tx_exc_r <= `EXC_ILLEGAL_FUNC;
					tx_len_r <= `EXC_RESP_LEN;
				end else if (!req_range_ok) begin
					tx_func_r <= `FUNC_READ_HOLDING | `FUNC_EXC_FLAG;
					tx_exc_r <= `EXC_ILLEGAL_ADDR;
					tx_len_r <= `EXC_RESP_LEN;
				end else begin
					tx_func_r <= `FUNC_READ_HOLDING; // Normal answer with the data
					tx_exc_r <= 8'h00;
					tx_len_r <= `RESP_HDR_LEN + {req_qty[6:0], 1'b0};
				end
			end
		end else if (tx_bcnt_r != BIT_CYC - 1) begin
			tx_bcnt_r <= tx_bcnt_r + 16'h0001;
		end else begin
			tx_bcnt_r <= 16'h0000;
			if (tx_bit_r != 4'h9) begin
				tx_pin_r <= tx_sh_r[0];
				tx_sh_r <= {1'b1, tx_sh_r[8:1]};
				tx_bit_r <= tx_bit_r + 4'h1;
			end else if (next_idx == tx_len_r) begin
				tx_busy_r <= 1'b0; // Driver released only after the last stop bit
				drive_n_r <= 1'b1;
			end else begin
				tx_idx_r <= next_idx;
				tx_bit_r <= 4'h0;
				tx_pin_r <= 1'b0;
				tx_sh_r <= {1'b1, byte_at(next_idx)};
				if (next_idx < tx_len_r - 8'h02)
					tx_crc_r <= crc_upd(tx_crc_r, byte_at(next_idx));
			end
		end
	end
	// Pins and status come straight from their flip-flops
	assign rs485_tx_out = tx_pin_r;
	assign rs485_drive_n_out = drive_n_r;
	assign bus_addr_out = addr_r;
	assign poll_busy_out = tx_busy_r;
endmodule // meter_serial_register_slave

// File: poll_master_model.sv
// Polling master on the serial line: sends and receives 8N1 characters.
// Assumes the slave's transmit line idles high; the model holds its line high when idle.
`timescale 1ns/1ns
module poll_master_model #(
	parameter BIT_CYC = 16
) (
	input wire clk_in,
	input wire rs485_tx_in,
	output reg rs485_rx_out
);
	initial rs485_rx_out = 1'b1;
	// One character, start bit, LSB first, one stop bit
	task send_byte(input [7:0] b);
		reg [9:0] f;
		integer i;
		begin
			f = {1'b1, b, 1'b0};
			for (i = 0; i < 10; i = i + 1) begin
				rs485_rx_out <= f[i];
				repeat (BIT_CYC) @(posedge clk_in);
			end
		end
	endtask
	// Bounded wait for a start bit, then mid-cell sampling to dodge edge races
	task recv_byte(input integer tmo, output [7:0] b, output ok);
		integer i;
		begin
			ok = 1'b0;
			b = 8'h00;
			for (i = 0; i < tmo && rs485_tx_in !== 1'b0; i = i + 1)
				@(posedge clk_in);
			if (rs485_tx_in === 1'b0) begin
				repeat (BIT_CYC / 2) @(posedge clk_in);
				for (i = 0; i < 8; i = i + 1) begin
					repeat (BIT_CYC) @(posedge clk_in);
					b[i] = rs485_tx_in;
				end
				repeat (BIT_CYC) @(posedge clk_in);
				ok = (rs485_tx_in === 1'b1);
			end
		end
	endtask
endmodule // poll_master_model

// File: tb.sv
// Testbench for the serial register slave, polling through the master model.
// Assumes a shortened bit time and frame gap on one 20 MHz clock.
`timescale 1ns/1ns
`include "meter_serial_defines.vh"
module tb;
	localparam BC = 16;
	localparam GC = 1120;
	reg clk_in = 1'b0;
	reg sys_rst_in = 1'b1;
	reg [3:0] serial_tens_in = 4'h4;
	reg [3:0] serial_ones_in = 4'h7;
	reg cfg_addr_load_in = 1'b0;
	reg [7:0] cfg_addr_in = 8'h00;
	reg [31:0] val [0:7];
	reg [10:0] fl = 11'h000;
	reg [31:0] exp_w;
	reg [7:0] rsp [0:15];
	wire rs485_rx_in;
	wire rs485_tx_out;
	wire rs485_drive_n_out;
	wire [7:0] bus_addr_out;
	wire poll_busy_out;
	integer err_total = 0;
	integer n_compared = 0;
	integer i;
	meter_serial_register_slave #(.BIT_CYC(BC), .GAP_CYC(GC)) meter_serial_register_slave_inst (
		.clk_in, .sys_rst_in, .rs485_rx_in, .serial_tens_in, .serial_ones_in, .cfg_addr_load_in, .cfg_addr_in,
		.gas_temperature_value_in(val[0]), .line_pressure_value_in(val[1]), .forward_velocity_value_in(val[2]),
		.forward_flow_value_in(val[3]), .forward_total_count_in(val[4]), .backward_velocity_value_in(val[5]),
		.backward_flow_value_in(val[6]), .backward_total_count_in(val[7]), .meas_over_range_in(fl[0]),
		.temp_over_range_in(fl[1]), .press_over_range_in(fl[2]), .pulse_over_range_in(fl[3]), .calib_overdue_in(fl[4]),
		.dp_sensor_fail_in(fl[5]), .press_sensor_fail_in(fl[6]), .temp_sensor_fail_in(fl[7]),
		.thermistor_element_fail_in(fl[8]), .reverse_flow_in(fl[9]), .wireless_service_module_in(fl[10]),
		.rs485_tx_out, .rs485_drive_n_out, .bus_addr_out, .poll_busy_out);
	poll_master_model #(.BIT_CYC(BC)) poll_master_model_inst (.clk_in, .rs485_tx_in(rs485_tx_out),
		.rs485_rx_out(rs485_rx_in));
	// Reflected check word update over one byte
	function [15:0] crc_upd(input [15:0] c, input [7:0] d);
		integer k;
		begin
			crc_upd = c ^ {8'h00, d};
			for (k = 0; k < 8; k = k + 1)
				crc_upd = crc_upd[0] ? (crc_upd >> 1) ^ 16'hA001 : crc_upd >> 1;
		end
	endfunction
	task chk(input [31:0] e, input [31:0] got, input [8*12:1] what);
		begin
			n_compared = n_compared + 1;
			if (got !== e) begin
				err_total = err_total + 1;
				$display("[ERR] %0s expected %h seen %h", what, e, got);
			end
		end
	endtask
	// Waits out any reply, sends one request, collects n reply bytes
	task poll(input [7:0] a, input [7:0] f, input [15:0] st, input [15:0] q, input integer n);
		reg [47:0] req;
		reg [15:0] c;
		reg ok;
		integer k;
		begin
			req = {a, f, st, q};
			c = 16'hFFFF;
			while (poll_busy_out !== 1'b0)
				@(posedge clk_in);
			@(posedge clk_in);
			for (k = 0; k < 6; k = k + 1) begin
				c = crc_upd(c, req[47 - 8 * k -: 8]);
				poll_master_model_inst.send_byte(req[47 - 8 * k -: 8]);
			end
			poll_master_model_inst.send_byte(c[7:0]);
			poll_master_model_inst.send_byte(c[15:8]);
			c = 16'hFFFF;
			for (k = 0; k < n; k = k + 1) begin
				poll_master_model_inst.recv_byte(GC + 40 * BC, rsp[k], ok);
				chk(1, ok, "reply byte");
				c = crc_upd(c, rsp[k]);
			end
			if (n > 0)
				chk(0, c, "reply crc");
		end
	endtask
	// Each of the eight measured values from its even start as two registers, reordered by the master
	task read_values;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				poll(8'h2F, `FUNC_READ_HOLDING, 16'(2 * i), 16'h0002, 9);
				chk({8'h2F, 8'h03, 8'h04}, {rsp[0], rsp[1], rsp[2]}, "header");
				chk(val[i], {rsp[5], rsp[6], rsp[3], rsp[4]}, "value");
				chk({val[i][7:0], val[i][15:8], val[i][23:16], val[i][31:24]}, {rsp[4], rsp[3], rsp[6], rsp[5]}, "value le");
			end
		end
	endtask
	// Two opposite flag patterns so each bit is seen set and clear
	task read_status;
		begin
			for (i = 0; i < 2; i = i + 1) begin
				@(posedge clk_in);
				fl <= i ? 11'h2AA : 11'h555;
				poll(8'h2F, `FUNC_READ_HOLDING, {8'h00, `REG_COND_FLAGS}, 16'h0002, 9);
				exp_w = {15'h0000, fl[10], fl[9], 3'h0, fl[8:5], 1'h0, fl[4:0], 2'h0};
				chk(exp_w, {rsp[5], rsp[6], rsp[3], rsp[4]}, "status");
			end
		end
	endtask
	// Unknown function, then a range past the end of the map
	task read_faults;
		begin
			poll(8'h2F, 8'h04, 16'h0000, 16'h0002, 5);
			chk({8'h84, 8'h01}, {rsp[1], rsp[2]}, "bad func");
			poll(8'h2F, `FUNC_READ_HOLDING, 16'h0019, 16'h0002, 5);
			chk({8'h83, 8'h02}, {rsp[1], rsp[2]}, "bad range");
			poll(8'h2F, `FUNC_READ_HOLDING, 16'h0000, 16'h0000, 5);
			chk({8'h83, 8'h02}, {rsp[1], rsp[2]}, "zero qty");
		end
	endtask
	// Foreign address stays silent until the address is reloaded at run time
	task readdress;
		begin
			poll(8'h2E, `FUNC_READ_HOLDING, 16'h0000, 16'h0002, 0);
			repeat (GC + 2 * BC) @(posedge clk_in);
			chk(0, poll_busy_out, "silent");
			cfg_addr_in <= 8'h2E;
			cfg_addr_load_in <= 1'b1;
			@(posedge clk_in);
			cfg_addr_load_in <= 1'b0;
			@(posedge clk_in);
			chk(8'h2E, bus_addr_out, "address");
			poll(8'h2E, `FUNC_READ_HOLDING, 16'h0000, 16'h0002, 9);
			chk(val[0], {rsp[5], rsp[6], rsp[3], rsp[4]}, "value");
		end
	endtask
	task report_and_stop;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// Clock
	initial forever #25 clk_in = ~clk_in;
	// Hang guard, well above the roughly 55000 cycles the polls need
	initial begin
		#(50 * 90000);
		err_total = err_total + 1;
		report_and_stop;
	end
	// Main sequence
	initial begin
		for (i = 0; i < 8; i = i + 1)
			val[i] <= 32'h11223344 + i * 32'h01010101;
		repeat (5) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(8'h2F, bus_addr_out, "strap addr");
		read_values;
		read_status;
		read_faults;
		readdress;
		report_and_stop;
	end
endmodule // tb
